/* eit_pkg.sv */
/*
 * Shared constants and types for the external interrupt and transfer
 * trigger block: register offsets, reset values, detection codes,
 * transfer sequencer states and the transfer request carrier.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package eit_pkg;

	localparam int NUM_IN = 5;
	localparam int ADDR_W = 8;

	// Register byte offsets
	localparam logic [7:0] ADDR_DETECT = 8'h00;
	localparam logic [7:0] ADDR_ENABLE = 8'h04;
	localparam logic [7:0] ADDR_CAUSE = 8'h08;
	localparam logic [7:0] ADDR_CLEAR = 8'h0C;
	localparam logic [7:0] ADDR_SERVICE = 8'h10;
	localparam logic [7:0] ADDR_COUNT0 = 8'h20;
	localparam logic [7:0] COUNT_STRIDE = 8'h04;

	// Values after reset
	localparam logic [9:0] RST_DETECT = 10'h000;
	localparam logic [4:0] RST_ENABLE = 5'h00;
	localparam logic [4:0] RST_CAUSE = 5'h00;
	localparam logic [4:0] RST_SERVICE = 5'h00;

	// Inputs routed to each vector line; bit 0 is the CAN receive input
	localparam logic [4:0] VEC15_MASK = 5'h01;
	localparam logic [4:0] VEC24_MASK = 5'h06;
	localparam logic [4:0] VEC27_MASK = 5'h18;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Bit 0 of the code is the polarity: high level or rising edge
	typedef enum logic [1:0] {
		DET_LOW = 2'h0,
		DET_HIGH = 2'h1,
		DET_FALL = 2'h2,
		DET_RISE = 2'h3
	} eit_detect_e;

	typedef enum logic [1:0] {
		XS_IDLE = 2'b01,
		XS_BUSY = 2'b10
	} eit_xfer_state_e;

	typedef struct packed {
		logic valid;
		logic [2:0] chan;
	} eit_xfer_req_s;

endpackage

/* eit_ext_irq.sv */
/*
 * External interrupt and automatic transfer trigger with AXI4-Lite
 * register slave. Five inputs (CAN receive plus four pins) are
 * synchronised, detected, latched and routed to interrupts or to
 * transfer requests. Assumes the pins are asynchronous to clk and the
 * transfer engine answers xfer_ack on clk.
 */
`timescale 1ns/10ps

module eit_ext_irq #(
	parameter int CNT_W = 8
) (
	input wire logic clk, // 125 MHz clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic can_rx, // CAN receive line
	input wire logic ext_irq_pin_a, // External pin a
	input wire logic ext_irq_pin_b, // External pin b
	input wire logic ext_irq_pin_c, // External pin c
	input wire logic ext_irq_pin_d, // External pin d
	output eit_pkg::eit_xfer_req_s xfer_req, // Transfer request to engine
	input wire logic xfer_ack, // Transfer done, one cycle
	output logic irq, // Combined interrupt
	output logic irq_vec15, // Vector 15 line
	output logic irq_vec24, // Vector 24 line
	output logic irq_vec27, // Vector 27 line
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready // Read data ready
);

	localparam int N = eit_pkg::NUM_IN;

	if (CNT_W < 1 || CNT_W > 16) begin : g_chk
		$error("CNT_W must lie between 1 and 16");
	end

	function automatic logic [31:0] merge(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// Index of the count register hit by addr, N when none
	function automatic logic [2:0] count_idx(input logic [7:0] addr);
		logic [2:0] r;
		r = 3'(N);
		for (int i = 0; i < N; i++) begin
			if (addr == eit_pkg::ADDR_COUNT0 +
					8'(i) * eit_pkg::COUNT_STRIDE) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	// Condition test of one input
	function automatic logic detect(input logic [1:0] mode,
			input logic xfer, input logic cur, input logic prev);
		logic r;
		r = 1'b0;
		if (xfer) begin
			r = (cur == mode[0]);
		end else begin
			case (mode)
				eit_pkg::DET_LOW: r = !cur;
				eit_pkg::DET_HIGH: r = cur;
				eit_pkg::DET_FALL: r = prev && !cur;
				eit_pkg::DET_RISE: r = !prev && cur;
				default: r = 1'b0;
			endcase
		end
		return r;
	endfunction

	logic [N-1:0] raw;
	logic [N-1:0] sync1_q;
	logic [N-1:0] sync2_q;
	logic [N-1:0] prev_q;
	logic [9:0] detect_q;
	logic [N-1:0] enable_q;
	logic [N-1:0] cause_q;
	logic [N-1:0] cause_d;
	logic [N-1:0] service_q;
	logic [CNT_W-1:0] count_q [N];
	logic [N-1:0] cond;
	logic [N-1:0] ack_clr;
	logic [N-1:0] ack_last;
	logic [N-1:0] pending;
	logic [N-1:0] live;
	eit_pkg::eit_xfer_state_e xs_q;
	eit_pkg::eit_xfer_req_s req_q;

	logic aw_hold_q;
	logic [7:0] aw_addr_q;
	logic w_hold_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic do_write;
	logic wr_detect;
	logic wr_enable;
	logic wr_clear;
	logic wr_service;
	logic wr_ok;
	logic [2:0] wr_cidx;
	logic [2:0] rd_cidx;
	logic [N-1:0] sw_clr;
	logic [31:0] wr_word;
	logic irq_q;
	logic vec15_q;
	logic vec24_q;
	logic vec27_q;

	// Bit 0 is the CAN receive line, used as a wakeup source
	assign raw = {ext_irq_pin_d, ext_irq_pin_c, ext_irq_pin_b,
		ext_irq_pin_a, can_rx};

	// Reset to the quiet high level: the default low-level code must
	// not latch a false cause while the pipeline refills after reset
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_q <= '1;
			sync2_q <= '1;
			prev_q <= '1;
		end else begin
			sync1_q <= raw;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	always_comb begin
		for (int i = 0; i < N; i++) begin
			cond[i] = detect(detect_q[2*i +: 2], service_q[i],
				sync2_q[i], prev_q[i]);
		end
	end

	// Register write decode
	assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
	assign wr_cidx = count_idx(aw_addr_q);
	assign rd_cidx = count_idx(s_axi_araddr);

	always_comb begin
		wr_detect = 1'b0;
		wr_enable = 1'b0;
		wr_clear = 1'b0;
		wr_service = 1'b0;
		wr_ok = 1'b1;
		if (aw_addr_q == eit_pkg::ADDR_DETECT) begin
			wr_detect = do_write;
		end else if (aw_addr_q == eit_pkg::ADDR_ENABLE) begin
			wr_enable = do_write;
		end else if (aw_addr_q == eit_pkg::ADDR_CLEAR) begin
			wr_clear = do_write;
		end else if (aw_addr_q == eit_pkg::ADDR_SERVICE) begin
			wr_service = do_write;
		end else if (aw_addr_q == eit_pkg::ADDR_CAUSE) begin
			wr_ok = 1'b1;
		end else if (wr_cidx == 3'(N)) begin
			wr_ok = 1'b0;
		end
	end

	assign wr_word = merge(32'h0000_0000, w_data_q, w_strb_q);
	assign sw_clr = wr_clear ? wr_word[N-1:0] : '0;

	// Transfer completion: the last transfer leaves the flag for the CPU
	always_comb begin
		ack_clr = '0;
		ack_last = '0;
		if (xs_q == eit_pkg::XS_BUSY && xfer_ack) begin
			if (count_q[req_q.chan] <= CNT_W'(1)) begin
				ack_last[req_q.chan] = 1'b1;
			end else begin
				ack_clr[req_q.chan] = 1'b1;
			end
		end
	end

	// A new condition wins over a clear in the same cycle
	assign cause_d = cond | (cause_q & ~(sw_clr | ack_clr));

	always_ff @(posedge clk) begin
		if (rst) begin
			cause_q <= eit_pkg::RST_CAUSE;
		end else begin
			cause_q <= cause_d;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			detect_q <= eit_pkg::RST_DETECT;
			enable_q <= eit_pkg::RST_ENABLE;
		end else begin
			if (wr_detect) begin
				detect_q <= 10'(merge(32'(detect_q), w_data_q,
					w_strb_q));
			end
			if (wr_enable) begin
				enable_q <= N'(merge(32'(enable_q), w_data_q,
					w_strb_q));
			end
		end
	end

	// Hardware drops the service bit after the final transfer
	always_ff @(posedge clk) begin
		if (rst) begin
			service_q <= eit_pkg::RST_SERVICE;
		end else if (wr_service) begin
			service_q <= N'(merge(32'(service_q), w_data_q,
				w_strb_q));
		end else begin
			service_q <= service_q & ~ack_last;
		end
	end

	// Software writes override the hardware decrement
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < N; i++) begin
				count_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < N; i++) begin
				if (do_write && wr_cidx == 3'(i)) begin
					count_q[i] <= CNT_W'(merge(32'(count_q[i]),
						w_data_q, w_strb_q));
				end else if ((ack_clr[i] || ack_last[i]) &&
						count_q[i] != '0) begin
					count_q[i] <= count_q[i] - CNT_W'(1);
				end
			end
		end
	end

	// Transfer sequencer, lowest input first
	assign pending = cause_q & enable_q & service_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			xs_q <= eit_pkg::XS_IDLE;
			req_q <= '0;
		end else begin
			case (xs_q)
				eit_pkg::XS_IDLE: begin
					for (int i = N - 1; i >= 0; i--) begin
						if (pending[i]) begin
							req_q.valid <= 1'b1;
							req_q.chan <= 3'(i);
							xs_q <= eit_pkg::XS_BUSY;
						end
					end
				end
				eit_pkg::XS_BUSY: begin
					if (xfer_ack) begin
						req_q.valid <= 1'b0;
						xs_q <= eit_pkg::XS_IDLE;
					end
				end
				default: begin
					xs_q <= eit_pkg::XS_IDLE;
					req_q <= '0;
				end
			endcase
		end
	end

	assign xfer_req = req_q;

	// Interrupt only for inputs on the ordinary path
	assign live = cause_q & enable_q & ~service_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_q <= 1'b0;
			vec15_q <= 1'b0;
			vec24_q <= 1'b0;
			vec27_q <= 1'b0;
		end else begin
			irq_q <= |live;
			vec15_q <= |(live & eit_pkg::VEC15_MASK);
			vec24_q <= |(live & eit_pkg::VEC24_MASK);
			vec27_q <= |(live & eit_pkg::VEC27_MASK);
		end
	end

	assign irq = irq_q;
	assign irq_vec15 = vec15_q;
	assign irq_vec24 = vec24_q;
	assign irq_vec27 = vec27_q;

	// AXI4-Lite write channels, address and data in either order
	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready = !w_hold_q && !bvalid_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			aw_hold_q <= 1'b0;
			aw_addr_q <= '0;
			w_hold_q <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= eit_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_ok ? eit_pkg::RESP_OKAY
					: eit_pkg::RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// Read channel; the clear register reads as zero
	assign s_axi_arready = !rvalid_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= eit_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rresp_q <= eit_pkg::RESP_OKAY;
			rdata_q <= '0;
			if (s_axi_araddr == eit_pkg::ADDR_DETECT) begin
				rdata_q <= 32'(detect_q);
			end else if (s_axi_araddr == eit_pkg::ADDR_ENABLE) begin
				rdata_q <= 32'(enable_q);
			end else if (s_axi_araddr == eit_pkg::ADDR_CAUSE) begin
				rdata_q <= 32'(cause_q);
			end else if (s_axi_araddr == eit_pkg::ADDR_CLEAR) begin
				rdata_q <= '0;
			end else if (s_axi_araddr == eit_pkg::ADDR_SERVICE) begin
				rdata_q <= 32'(service_q);
			end else if (rd_cidx != 3'(N)) begin
				rdata_q <= 32'(count_q[rd_cidx]);
			end else begin
				rresp_q <= eit_pkg::RESP_SLVERR;
			end
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

endmodule

/* eit_ext_irq_asserts.sv */
/* Port checker for eit_ext_irq.
   Bound into every eit_ext_irq; reads its ports only. */
`timescale 1ns/10ps
module eit_ext_irq_chk (
	input wire logic clk, // Clock
	input wire logic rst, // Reset
	input wire eit_pkg::eit_xfer_req_s xfer_req, // Request
	input wire logic xfer_ack, // Ack
	input wire logic irq, // Interrupt
	input wire logic irq_vec15, // Vector 15
	input wire logic irq_vec24, // Vector 24
	input wire logic irq_vec27, // Vector 27
	input wire logic s_axi_awvalid, // AW valid
	input wire logic s_axi_awready, // AW ready
	input wire logic s_axi_wvalid, // W valid
	input wire logic s_axi_wready, // W ready
	input wire logic s_axi_bvalid, // B valid
	input wire logic s_axi_arvalid, // AR valid
	input wire logic s_axi_arready, // AR ready
	input wire logic s_axi_rvalid, // R valid
	input wire logic s_axi_rready, // R ready
	input wire logic [31:0] s_axi_rdata // R data
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (rst);
	irq_vec_or_a: assert property (
		irq == (irq_vec15 | irq_vec24 | irq_vec27))
		else $error("irq differs from vector lines");
	req_hold_a: assert property (
		xfer_req.valid && !xfer_ack |=>
		xfer_req.valid && $stable(xfer_req.chan))
		else $error("request not held");
	req_drop_a: assert property (
		xfer_req.valid && xfer_ack |=> !xfer_req.valid)
		else $error("request kept after ack");
	chan_range_a: assert property (
		xfer_req.valid |-> xfer_req.chan <= 3'h4)
		else $error("channel out of range");
	rd_latency_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	rd_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	rd_refuse_a: assert property (
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");
	wr_answer_a: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	irq_seen_c: cover property (irq);
	xfer_done_c: cover property (xfer_req.valid && xfer_ack);
	wr_done_c: cover property (s_axi_bvalid);
endmodule

bind eit_ext_irq eit_ext_irq_chk chk (.clk, .rst, .xfer_req,
	.xfer_ack, .irq, .irq_vec15, .irq_vec24, .irq_vec27,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rdata);

/* eit_periph.sv */
/* Far-side model: pin drivers and transfer engine.
   Pin levels come from the bench; acks follow the request. */
`timescale 1ns/10ps
module eit_periph (
	input wire logic clk, // Clock
	input wire logic rst, // Reset
	input wire logic [4:0] lvl, // Wanted pin levels
	input wire eit_pkg::eit_xfer_req_s xfer_req, // Request
	output logic can_rx, // CAN receive
	output logic ext_irq_pin_a, // Pin a
	output logic ext_irq_pin_b, // Pin b
	output logic ext_irq_pin_c, // Pin c
	output logic ext_irq_pin_d, // Pin d
	output logic xfer_ack, // Done pulse
	output logic [7:0] acks, // Transfers served
	output logic [2:0] last_chan // Last channel
);
	logic [2:0] wait_q;
	assign {ext_irq_pin_d, ext_irq_pin_c, ext_irq_pin_b, ext_irq_pin_a,
		can_rx} = lvl;
	// Every second transfer answers slowly so both timings are exercised
	always_ff @(posedge clk) begin
		if (rst) begin
			xfer_ack <= 1'b0;
			acks <= 8'h00;
			wait_q <= 3'h0;
			last_chan <= 3'h0;
		end else begin
			xfer_ack <= 1'b0;
			if (xfer_req.valid && !xfer_ack) begin
				if (wait_q == (acks[0] ? 3'h4 : 3'h0)) begin
					xfer_ack <= 1'b1;
					acks <= acks + 8'h01;
					last_chan <= xfer_req.chan;
					wait_q <= 3'h0;
				end else begin
					wait_q <= wait_q + 3'h1;
				end
			end
		end
	end
endmodule

/* external_interrupt_transfer_trigger_test.sv */
/* Bench for eit_ext_irq with the eit_periph model.
   Needs eit_pkg, the design and its checker compiled first. */
`timescale 1ns/10ps
module external_interrupt_transfer_trigger_test;
	logic clk = 1'b0;
	logic rst;
	logic [4:0] lvl;
	logic can_rx, ext_irq_pin_a, ext_irq_pin_b, ext_irq_pin_c;
	logic ext_irq_pin_d, xfer_ack, irq, irq_vec15, irq_vec24, irq_vec27;
	eit_pkg::eit_xfer_req_s xfer_req;
	logic [7:0] s_axi_awaddr, s_axi_araddr, acks;
	logic [2:0] last_chan;
	logic [31:0] s_axi_wdata, s_axi_rdata, v, resp;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	int failures = 0;
	int num_checks = 0;
	int cyc = 0;

	always #4 clk = ~clk;

	eit_ext_irq #(.CNT_W(8)) uut (.clk, .rst, .can_rx, .ext_irq_pin_a,
		.ext_irq_pin_b, .ext_irq_pin_c, .ext_irq_pin_d, .xfer_req,
		.xfer_ack, .irq, .irq_vec15, .irq_vec24, .irq_vec27,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	eit_periph p (.clk, .rst, .lvl, .xfer_req, .can_rx, .ext_irq_pin_a,
		.ext_irq_pin_b, .ext_irq_pin_c, .ext_irq_pin_d, .xfer_ack,
		.acks, .last_chan);

	task automatic complete_run();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	// Handshakes are judged at the falling edge, where ready is settled
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w, ok;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge clk);
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			ok = s_axi_bvalid;
			resp = {30'h0, s_axi_bresp};
			@(posedge clk);
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
		end while (!ok);
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic ar, ok;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge clk);
			ar = s_axi_arready;
			ok = s_axi_rvalid;
			v = s_axi_rdata;
			resp = {30'h0, s_axi_rresp};
			@(posedge clk);
			if (ar)
				s_axi_arvalid <= 1'b0;
		end while (!ok);
		s_axi_rready <= 1'b0;
		@(posedge clk);
		chk(v, e);
	endtask

	task automatic vchk(input logic [31:0] en, input logic [3:0] e);
		wr(eit_pkg::ADDR_ENABLE, en);
		@(negedge clk);
		chk({28'h0, irq, irq_vec27, irq_vec24, irq_vec15}, {28'h0, e});
		@(posedge clk);
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			failures++;
			complete_run();
		end
	end

	initial begin
		rst = 1'b1;
		lvl = 5'h1F;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rc(eit_pkg::ADDR_DETECT, 32'h0);
		rc(eit_pkg::ADDR_ENABLE, 32'h0);
		rc(eit_pkg::ADDR_CAUSE, 32'h0);
		rc(eit_pkg::ADDR_SERVICE, 32'h0);
		rc(eit_pkg::ADDR_CLEAR, 32'h0);
		rc(8'h14, 32'h0);
		chk(resp, {30'h0, eit_pkg::RESP_SLVERR});
		wr(8'h14, 32'h1F);
		chk(resp, {30'h0, eit_pkg::RESP_SLVERR});
		wr(eit_pkg::ADDR_ENABLE, 32'h1F);
		chk(resp, {30'h0, eit_pkg::RESP_OKAY});
		// Every code on all five inputs; quiet level is the inverse
		for (int c = 0; c < 4; c++) begin
			lvl <= {5{~c[0]}};
			wr(eit_pkg::ADDR_DETECT, {22'h0, {5{2'(c)}}});
			repeat (4) @(posedge clk);
			wr(eit_pkg::ADDR_CLEAR, 32'h1F);
			rc(eit_pkg::ADDR_CAUSE, 32'h0);
			lvl <= {5{c[0]}};
			repeat (4) @(posedge clk);
			lvl <= {5{~c[0]}};
			repeat (4) @(posedge clk);
			rc(eit_pkg::ADDR_CAUSE, 32'h1F);
			chk({31'h0, irq}, 32'h1);
		end
		chk({24'h0, acks}, 32'h0);
		vchk(32'h08, 4'hC);
		vchk(32'h06, 4'hA);
		vchk(32'h01, 4'h9);
		vchk(32'h00, 4'h0);
		rc(eit_pkg::ADDR_CAUSE, 32'h1F);
		wr(eit_pkg::ADDR_CLEAR, 32'h1F);
		// Input 2 on the transfer path; rising code acts as high level
		wr(eit_pkg::ADDR_DETECT, 32'h3FF);
		wr(eit_pkg::ADDR_COUNT0 + 8'h08, 32'h2);
		wr(eit_pkg::ADDR_ENABLE, 32'h04);
		wr(eit_pkg::ADDR_SERVICE, 32'h04);
		lvl <= 5'h04;
		repeat (40) @(posedge clk);
		lvl <= 5'h00;
		repeat (4) @(posedge clk);
		chk({24'h0, acks}, 32'h2);
		chk({29'h0, last_chan}, 32'h2);
		rc(eit_pkg::ADDR_SERVICE, 32'h0);
		rc(eit_pkg::ADDR_COUNT0 + 8'h08, 32'h0);
		rc(eit_pkg::ADDR_CAUSE, 32'h04);
		chk({31'h0, irq}, 32'h1);
		wr(eit_pkg::ADDR_CLEAR, 32'h04);
		rc(eit_pkg::ADDR_CAUSE, 32'h0);
		chk({31'h0, irq}, 32'h0);
		// CAN input on the transfer path; falling code acts as low level
		wr(eit_pkg::ADDR_DETECT, 32'h3FE);
		wr(eit_pkg::ADDR_COUNT0, 32'h1);
		wr(eit_pkg::ADDR_ENABLE, 32'h01);
		wr(eit_pkg::ADDR_SERVICE, 32'h01);
		repeat (12) @(posedge clk);
		chk({24'h0, acks}, 32'h3);
		chk({29'h0, last_chan}, 32'h0);
		rc(eit_pkg::ADDR_SERVICE, 32'h0);
		chk({31'h0, irq_vec15}, 32'h1);
		wr(eit_pkg::ADDR_CLEAR, 32'h01);
		rc(eit_pkg::ADDR_CAUSE, 32'h0);
		complete_run();
	end
endmodule
